// >>> aerms_evt_if.sv
`timescale 1ns/100ps
interface aerms_evt_if;
    import aerms_pkg::*;

    logic [DATA_W-1:0] uncHit;
    logic [DATA_W-1:0] uncSev;
    logic [DATA_W-1:0] corHit;
    logic msgFatal;
    logic msgNonFatal;
    logic msgCor;

    modport core (
        output uncHit,
        output uncSev,
        output corHit,
        input msgFatal,
        input msgNonFatal,
        input msgCor
    );

    modport report (
        input uncHit,
        input uncSev,
        input corHit,
        output msgFatal,
        output msgNonFatal,
        output msgCor
    );
endinterface

// >>> aerms_pkg.sv
package aerms_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int UNC_W = 22;
    localparam int COR_W = 14;
    localparam int FEP_W = 5;
    localparam int BE_W = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration space byte offsets
    localparam logic [ADDR_W-1:0] OFF_UNC_STATUS = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_UNC_MASK = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_UNC_SEV = 12'h10c;
    localparam logic [ADDR_W-1:0] OFF_COR_STATUS = 12'h110;
    localparam logic [ADDR_W-1:0] OFF_COR_MASK = 12'h114;
    localparam logic [ADDR_W-1:0] OFF_CAP_CTRL = 12'h118;

    ////////////////////////////////////////////////////////////////////////////////
    // uncorrectable bit positions, shared by status, mask and severity
    localparam int UNC_TRAINING = 0;
    localparam int UNC_DL_PROTOCOL = 4;
    localparam int UNC_POISONED = 12;
    localparam int UNC_FC_PROTOCOL = 13;
    localparam int UNC_CPL_TIMEOUT = 14;
    localparam int UNC_CPL_ABORT = 15;
    localparam int UNC_UNEXP_CPL = 16;
    localparam int UNC_RX_OVERFLOW = 17;
    localparam int UNC_MALFORMED = 18;
    localparam int UNC_ECRC = 19;
    localparam int UNC_UNSUP_REQ = 20;
    localparam int UNC_ACS_VIOL = 21;

    // correctable bit positions, shared by status and mask
    localparam int COR_RX_ERR = 0;
    localparam int COR_BAD_TLP = 6;
    localparam int COR_BAD_DLLP = 7;
    localparam int COR_REPLAY_ROLL = 8;
    localparam int COR_REPLAY_TMO = 12;
    localparam int COR_ADVISORY = 13;

    // first error pointer field position in the capabilities and control word
    localparam int FEP_POS = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // implemented bits; everything else is reserved and reads zero
    localparam logic [DATA_W-1:0] UNC_IMPL = (32'h1 << UNC_TRAINING)
        | (32'h1 << UNC_DL_PROTOCOL) | (32'h1 << UNC_POISONED) | (32'h1 << UNC_FC_PROTOCOL)
        | (32'h1 << UNC_CPL_TIMEOUT) | (32'h1 << UNC_CPL_ABORT) | (32'h1 << UNC_UNEXP_CPL)
        | (32'h1 << UNC_RX_OVERFLOW) | (32'h1 << UNC_MALFORMED) | (32'h1 << UNC_ECRC)
        | (32'h1 << UNC_UNSUP_REQ) | (32'h1 << UNC_ACS_VIOL);
    localparam logic [DATA_W-1:0] COR_IMPL = (32'h1 << COR_RX_ERR)
        | (32'h1 << COR_BAD_TLP) | (32'h1 << COR_BAD_DLLP) | (32'h1 << COR_REPLAY_ROLL)
        | (32'h1 << COR_REPLAY_TMO) | (32'h1 << COR_ADVISORY);

    // reset values
    localparam logic [DATA_W-1:0] UNC_STATUS_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] UNC_MASK_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] UNC_SEV_RST = (32'h1 << UNC_TRAINING)
        | (32'h1 << UNC_DL_PROTOCOL) | (32'h1 << UNC_FC_PROTOCOL)
        | (32'h1 << UNC_RX_OVERFLOW) | (32'h1 << UNC_MALFORMED);
    localparam logic [DATA_W-1:0] COR_STATUS_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] COR_MASK_RST = (32'h1 << COR_ADVISORY);
    localparam logic [FEP_W-1:0] FEP_RST = 5'h00;

endpackage

// >>> aerms_rc_model.sv
`timescale 1ns/100ps
// receiving end of error messages: counts each one-cycle message by class
module aerms_rc_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic msgFatal,
    input wire logic msgNonFatal,
    input wire logic msgCor,
    output int fatalCnt,
    output int nonFatalCnt,
    output int corCnt
);
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            fatalCnt <= 0;
            nonFatalCnt <= 0;
            corCnt <= 0;
        end else begin
            fatalCnt <= fatalCnt + int'(msgFatal);
            nonFatalCnt <= nonFatalCnt + int'(msgNonFatal);
            corCnt <= corCnt + int'(msgCor);
        end
    end
endmodule

// >>> aerms_reporter.sv
`timescale 1ns/100ps
module aerms_reporter (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hotLinkReset_n,
    aerms_evt_if.report evt
);
    import aerms_pkg::*;

    logic fatal_reg;
    logic fatal_next;
    logic nonFatal_reg;
    logic nonFatal_next;
    logic cor_reg;
    logic cor_next;

    // one message class per severity; both may fire in the same cycle
    always_comb begin
        fatal_next = |(evt.uncHit & evt.uncSev); // see RL9
        nonFatal_next = |(evt.uncHit & ~evt.uncSev); // see RL9
        cor_next = |evt.corHit;
    end

    // messages are not sticky, so a link reset drops a pending one
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !hotLinkReset_n) begin
            fatal_reg <= 1'b0;
            nonFatal_reg <= 1'b0;
            cor_reg <= 1'b0;
        end else begin
            fatal_reg <= fatal_next;
            nonFatal_reg <= nonFatal_next;
            cor_reg <= cor_next;
        end
    end

    assign evt.msgFatal = fatal_reg;
    assign evt.msgNonFatal = nonFatal_reg;
    assign evt.msgCor = cor_reg;
endmodule

// >>> aerms_sticky_bank.sv
`timescale 1ns/100ps
module aerms_sticky_bank
    import aerms_pkg::*;
#(
    parameter logic [aerms_pkg::DATA_W-1:0] IMPL = '0,
    parameter logic [aerms_pkg::DATA_W-1:0] RST = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [aerms_pkg::DATA_W-1:0] setVec,
    input wire logic [aerms_pkg::DATA_W-1:0] clrVec,
    output logic [aerms_pkg::DATA_W-1:0] flags
);
    import aerms_pkg::*;

    logic [DATA_W-1:0] flags_reg;
    logic [DATA_W-1:0] flags_next;

    // set is or-ed after the clear so an event in the clearing cycle survives
    always_comb begin
        flags_next = ((flags_reg & ~clrVec) | setVec) & IMPL;
    end

    // only the power-on reset reaches these flops; link resets do not
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flags_reg <= RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule

// >>> aerms_top.sv
// Operation
// RL1: mask bit 0 set stops logging and reporting of training errors; resets zero.
// RL2: mask bit 4 set stops logging and reporting of data link protocol errors.
// RL3: mask bit 12 set stops logging and reporting of poisoned packets.
// RL4: mask bit 13 set stops logging and reporting of flow control protocol errors.
// RL5: mask bits 14 and 15 gate completion timeout and completer abort.
// RL6: mask bits 16 and 17 gate unexpected completion and receiver overflow.
// RL7: mask bits 18 and 19 gate malformed packet and end-to-end CRC errors.
// RL8: mask bit 20 gates unsupported request; bit 21 sticky access violation mask.
// RL9: severity bit zero means non-fatal message, one means fatal message.
// RL10: severity resets fatal for bits 0, 4, 13, 17, 18; others non-fatal.
// RL11: correctable status bit 0 flags receiver error, sticky, write one clears.
// RL12: correctable bits 6 and 7 flag bad packet and bad link packet.
// RL13: correctable bits 8 and 12 flag replay rollover and replay timeout.
// RL14: correctable bit 13 flags advisory non-fatal error, write one clears.
// RL15: uncorrectable status shares bit positions, set by events, write one clears.
// RL16: correctable advisory mask bit 13 resets to one.
// RL17: sticky five-bit pointer holds position of first reported uncorrectable error.
// RL18: writing zero leaves status unchanged; reserved bits read zero, ignore writes.
// RL19: sticky bits survive hot and link resets; only power-on reset initialises.
`timescale 1ns/100ps
module aerms_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hotLinkReset_n,
    input wire logic [aerms_pkg::ADDR_W-1:0] cfgAddr,
    input wire logic cfgWrEn,
    input wire logic cfgRdEn,
    input wire logic [aerms_pkg::BE_W-1:0] cfgByteEn,
    input wire logic [aerms_pkg::DATA_W-1:0] cfgWrData,
    output logic [aerms_pkg::DATA_W-1:0] cfgRdData,
    output logic cfgRdValid,
    input wire logic [aerms_pkg::UNC_W-1:0] uncEvent,
    input wire logic [aerms_pkg::COR_W-1:0] corEvent,
    output logic msgFatal,
    output logic msgNonFatal,
    output logic msgCor,
    output logic hdrLogStrobe,
    output logic [aerms_pkg::FEP_W-1:0] firstErrPtr
);
    import aerms_pkg::*;

    aerms_evt_if evt ();

    logic [DATA_W-1:0] byteMask;
    logic [DATA_W-1:0] uncEvtWide;
    logic [DATA_W-1:0] corEvtWide;
    logic [DATA_W-1:0] uncStatus;
    logic [DATA_W-1:0] corStatus;
    logic [DATA_W-1:0] uncClr;
    logic [DATA_W-1:0] corClr;
    logic [DATA_W-1:0] uncMask_reg;
    logic [DATA_W-1:0] uncMask_next;
    logic [DATA_W-1:0] uncSev_reg;
    logic [DATA_W-1:0] uncSev_next;
    logic [DATA_W-1:0] corMask_reg;
    logic [DATA_W-1:0] corMask_next;
    logic [FEP_W-1:0] fep_reg;
    logic [FEP_W-1:0] fep_next;
    logic hdrLog_reg;
    logic hdrLog_next;
    logic [DATA_W-1:0] rdData_reg;
    logic [DATA_W-1:0] rdData_next;
    logic rdValid_reg;
    logic rdValid_next;

    ////////////////////////////////////////////////////////////////////////////////
    // write decode helpers

    genvar gb;
    generate
        for (gb = 0; gb < BE_W; gb++) begin : gByte
            assign byteMask[gb*8 +: 8] = {8{cfgByteEn[gb]}};
        end
    endgenerate

    assign uncEvtWide = {{(DATA_W-UNC_W){1'b0}}, uncEvent};
    assign corEvtWide = {{(DATA_W-COR_W){1'b0}}, corEvent};

    // writing zero clears nothing: only ones in enabled lanes reach the clear
    always_comb begin
        uncClr = '0;
        corClr = '0;
        if (cfgWrEn && cfgAddr == OFF_UNC_STATUS) begin
            uncClr = cfgWrData & byteMask; // see RL15 RL18
        end else if (cfgWrEn && cfgAddr == OFF_COR_STATUS) begin
            corClr = cfgWrData & byteMask; // see RL11 RL12 RL13 RL14 RL18
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky status banks; raw events set status even when masked

    aerms_sticky_bank #(
        .IMPL(UNC_IMPL),
        .RST(UNC_STATUS_RST)
    ) uUncStatus (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .setVec(uncEvtWide), // see RL15
        .clrVec(uncClr),
        .flags(uncStatus)
    );

    aerms_sticky_bank #(
        .IMPL(COR_IMPL),
        .RST(COR_STATUS_RST)
    ) uCorStatus (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .setVec(corEvtWide), // see RL11 RL12 RL13 RL14
        .clrVec(corClr),
        .flags(corStatus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // sticky mask and severity registers

    always_comb begin
        uncMask_next = uncMask_reg;
        uncSev_next = uncSev_reg;
        corMask_next = corMask_reg;
        if (cfgWrEn && cfgAddr == OFF_UNC_MASK) begin
            uncMask_next = ((uncMask_reg & ~byteMask) | (cfgWrData & byteMask)) & UNC_IMPL; // see RL8
        end else if (cfgWrEn && cfgAddr == OFF_UNC_SEV) begin
            uncSev_next = ((uncSev_reg & ~byteMask) | (cfgWrData & byteMask)) & UNC_IMPL; // see RL9
        end else if (cfgWrEn && cfgAddr == OFF_COR_MASK) begin
            corMask_next = ((corMask_reg & ~byteMask) | (cfgWrData & byteMask)) & COR_IMPL;
        end
    end

    // hot and link resets deliberately do not reach these flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin // see RL19
            uncMask_reg <= UNC_MASK_RST; // see RL1 RL8
            uncSev_reg <= UNC_SEV_RST; // see RL10
            corMask_reg <= COR_MASK_RST; // see RL16
        end else begin
            uncMask_reg <= uncMask_next;
            uncSev_reg <= uncSev_next;
            corMask_reg <= corMask_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // masking toward header log and messages

    assign evt.uncHit = uncEvtWide & ~uncMask_reg & UNC_IMPL; // see RL1 RL2 RL3 RL4 RL5 RL6 RL7 RL8
    assign evt.uncSev = uncSev_reg;
    assign evt.corHit = corEvtWide & ~corMask_reg & COR_IMPL; // see RL16

    aerms_reporter uReport (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .hotLinkReset_n(hotLinkReset_n),
        .evt(evt.report)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // first error pointer and header log capture

    // a new pointer is taken only once the bit it names has been cleared
    always_comb begin
        fep_next = fep_reg;
        hdrLog_next = 1'b0;
        // a link reset holds back both capture and pointer, so they stay in step
        if (hotLinkReset_n && !uncStatus[fep_reg] && |evt.uncHit) begin
            hdrLog_next = 1'b1; // see RL1 RL2 RL3 RL4 RL5 RL6 RL7 RL8
            for (int i = DATA_W - 1; i >= 0; i--) begin
                if (evt.uncHit[i]) begin
                    fep_next = FEP_W'(i); // see RL17
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fep_reg <= FEP_RST; // see RL19
            hdrLog_reg <= 1'b0;
        end else begin
            fep_reg <= fep_next;
            hdrLog_reg <= hdrLog_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path; unmapped offsets return zero

    always_comb begin
        rdData_next = rdData_reg;
        rdValid_next = cfgRdEn;
        if (cfgRdEn) begin
            if (cfgAddr == OFF_UNC_STATUS) begin
                rdData_next = uncStatus;
            end else if (cfgAddr == OFF_UNC_MASK) begin
                rdData_next = uncMask_reg;
            end else if (cfgAddr == OFF_UNC_SEV) begin
                rdData_next = uncSev_reg;
            end else if (cfgAddr == OFF_COR_STATUS) begin
                rdData_next = corStatus;
            end else if (cfgAddr == OFF_COR_MASK) begin
                rdData_next = corMask_reg;
            end else if (cfgAddr == OFF_CAP_CTRL) begin
                rdData_next = DATA_W'(fep_reg) << FEP_POS; // see RL17
            end else begin
                rdData_next = '0; // see RL18
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdData_reg <= '0;
            rdValid_reg <= 1'b0;
        end else begin
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
        end
    end

    assign cfgRdData = rdData_reg;
    assign cfgRdValid = rdValid_reg;
    assign msgFatal = evt.msgFatal;
    assign msgNonFatal = evt.msgNonFatal;
    assign msgCor = evt.msgCor;
    assign hdrLogStrobe = hdrLog_reg;
    assign firstErrPtr = fep_reg;
endmodule

// >>> aerms_top_assertions.sv
`timescale 1ns/100ps
module aerms_top_assertions
    import aerms_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hotLinkReset_n,
    input wire logic [aerms_pkg::ADDR_W-1:0] cfgAddr,
    input wire logic cfgWrEn,
    input wire logic cfgRdEn,
    input wire logic [aerms_pkg::BE_W-1:0] cfgByteEn,
    input wire logic [aerms_pkg::DATA_W-1:0] cfgWrData,
    input wire logic [aerms_pkg::DATA_W-1:0] cfgRdData,
    input wire logic cfgRdValid,
    input wire logic [aerms_pkg::UNC_W-1:0] uncEvent,
    input wire logic [aerms_pkg::COR_W-1:0] corEvent,
    input wire logic msgFatal,
    input wire logic msgNonFatal,
    input wire logic msgCor,
    input wire logic hdrLogStrobe,
    input wire logic [aerms_pkg::FEP_W-1:0] firstErrPtr
);
    logic [DATA_W-1:0] uMask_reg, uMask_next, uSev_reg, uSev_next, cMask_reg, cMask_next;
    logic [UNC_W-1:0] um;
    logic [COR_W-1:0] cm;

    function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, logic [ADDR_W-1:0] a);
        merge = o;
        for (int i = 0; i < BE_W; i++) begin
            if (cfgWrEn && cfgAddr == a && cfgByteEn[i]) begin
                merge[8*i+:8] = cfgWrData[8*i+:8];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // own copies of the masks, so routing is judged without trusting the design
    always_comb begin
        uMask_next = merge(uMask_reg, OFF_UNC_MASK);
        uSev_next = merge(uSev_reg, OFF_UNC_SEV);
        cMask_next = merge(cMask_reg, OFF_COR_MASK);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            uMask_reg <= UNC_MASK_RST;
            uSev_reg <= UNC_SEV_RST;
            cMask_reg <= COR_MASK_RST;
        end else begin
            uMask_reg <= uMask_next;
            uSev_reg <= uSev_next;
            cMask_reg <= cMask_next;
        end
    end

    assign um = uncEvent & UNC_IMPL[UNC_W-1:0] & ~uMask_reg[UNC_W-1:0];
    assign cm = corEvent & COR_IMPL[COR_W-1:0] & ~cMask_reg[COR_W-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_rd_answer;
        cfgRdEn ##1 cfgRdValid;
    endsequence

    sequence s_quiet;
        !msgFatal && !msgNonFatal && !msgCor && !hdrLogStrobe;
    endsequence

    a_rd_answer: assert property (cfgRdEn |-> s_rd_answer)
        else $error("read strobe got no valid one cycle later");
    a_rd_unasked: assert property (!cfgRdEn |=> !cfgRdValid)
        else $error("read valid without a read strobe");
    a_rd_hold: assert property (!cfgRdValid |-> $stable(cfgRdData))
        else $error("read data changed without a read");
    a_fatal_class: assert property (hotLinkReset_n |=> msgFatal == $past(|(um & uSev_reg[UNC_W-1:0])))
        else $error("fatal message does not match unmasked fatal events");
    a_nonfatal_class: assert property (hotLinkReset_n |=> msgNonFatal == $past(|(um & ~uSev_reg[UNC_W-1:0])))
        else $error("non-fatal message does not match unmasked events");
    a_cor_report: assert property (hotLinkReset_n |=> msgCor == $past(|cm))
        else $error("correctable message does not match unmasked events");
    a_hot_quiet: assert property (!hotLinkReset_n |=> s_quiet)
        else $error("pulse during link reset");
    a_hdr_unmasked: assert property (hdrLogStrobe |-> $past(|um))
        else $error("header strobe without an unmasked event");
    a_ptr_hold: assert property (!hdrLogStrobe |-> $stable(firstErrPtr))
        else $error("pointer moved without a header capture");
    a_ptr_lowest: assert property (hdrLogStrobe |-> ($past(um) & ((22'h1 << firstErrPtr) | ((22'h1 << firstErrPtr) - 22'h1))) == (22'h1 << firstErrPtr))
        else $error("pointer is not the lowest unmasked event");
endmodule

bind aerms_top aerms_top_assertions u_aerms_top_assertions (
    .sys_clk(sys_clk), .rst_n(rst_n), .hotLinkReset_n(hotLinkReset_n), .cfgAddr(cfgAddr),
    .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .uncEvent(uncEvent), .corEvent(corEvent),
    .msgFatal(msgFatal), .msgNonFatal(msgNonFatal), .msgCor(msgCor),
    .hdrLogStrobe(hdrLogStrobe), .firstErrPtr(firstErrPtr)
);

// >>> aerms_top_test.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module aerms_top_test;
    import aerms_pkg::*;
    localparam int UPOS [12] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
    localparam int CPOS [6] = '{0, 6, 7, 8, 12, 13};
    logic sys_clk, rst_n, hotLinkReset_n, cfgWrEn, cfgRdEn, cfgRdValid;
    logic msgFatal, msgNonFatal, msgCor, hdrLogStrobe;
    logic [ADDR_W-1:0] cfgAddr;
    logic [BE_W-1:0] cfgByteEn;
    logic [DATA_W-1:0] cfgWrData, cfgRdData;
    logic [UNC_W-1:0] uncEvent;
    logic [COR_W-1:0] corEvent;
    logic [FEP_W-1:0] firstErrPtr;
    int num_errors, cmp_count, expFat, expNon, expCor, fatalCnt, nonFatalCnt, corCnt;

    aerms_top u_aerms_top (.sys_clk(sys_clk), .rst_n(rst_n), .hotLinkReset_n(hotLinkReset_n),
        .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgByteEn(cfgByteEn),
        .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .uncEvent(uncEvent), .corEvent(corEvent), .msgFatal(msgFatal),
        .msgNonFatal(msgNonFatal), .msgCor(msgCor), .hdrLogStrobe(hdrLogStrobe),
        .firstErrPtr(firstErrPtr));
    aerms_rc_model u_aerms_rc_model (.sys_clk(sys_clk), .rst_n(rst_n), .msgFatal(msgFatal),
        .msgNonFatal(msgNonFatal), .msgCor(msgCor), .fatalCnt(fatalCnt),
        .nonFatalCnt(nonFatalCnt), .corCnt(corCnt));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic [BE_W-1:0] be = 4'hf);
        @(posedge sys_clk);
        cfgAddr <= a;
        cfgWrData <= d;
        cfgByteEn <= be;
        cfgWrEn <= 1'b1;
        @(posedge sys_clk);
        cfgWrEn <= 1'b0;
    endtask

    task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        @(posedge sys_clk);
        cfgAddr <= a;
        cfgRdEn <= 1'b1;
        @(posedge sys_clk);
        cfgRdEn <= 1'b0;
        #1;
        `CHK("read valid", 1'b1, cfgRdValid)
        `CHK("read data", e, cfgRdData)
    endtask

    // one event cycle; messages are one-cycle pulses, so they are looked at right away
    task automatic ev(logic [UNC_W-1:0] u, logic [COR_W-1:0] c, logic f, n, k, h);
        @(posedge sys_clk);
        uncEvent <= u;
        corEvent <= c;
        @(posedge sys_clk);
        uncEvent <= '0;
        corEvent <= '0;
        #1;
        `CHK("fatal message", f, msgFatal)
        `CHK("non-fatal message", n, msgNonFatal)
        `CHK("correctable message", k, msgCor)
        `CHK("header strobe", h, hdrLogStrobe)
        expFat += int'(f);
        expNon += int'(n);
        expCor += int'(k);
    endtask

    task automatic test_done;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        test_done;
    end

    initial begin
        {rst_n, cfgWrEn, cfgRdEn, cfgAddr, cfgByteEn, cfgWrData, uncEvent, corEvent} <= '0;
        hotLinkReset_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(OFF_UNC_MASK, UNC_MASK_RST);
        rd(OFF_UNC_SEV, UNC_SEV_RST);
        rd(OFF_COR_STATUS, COR_STATUS_RST);
        rd(OFF_COR_MASK, COR_MASK_RST);
        rd(OFF_UNC_STATUS, UNC_STATUS_RST);
        rd(12'h200, 32'h0);
        ev(22'h10, '0, 1'b1, 1'b0, 1'b0, 1'b1);
        rd(OFF_CAP_CTRL, 32'h4);
        rd(OFF_UNC_STATUS, 32'h10);
        ev(22'h1000, '0, 1'b0, 1'b1, 1'b0, 1'b0);
        // every mask bit on: events still land in status but stay silent
        wr(OFF_UNC_MASK, 32'hffffffff);
        rd(OFF_UNC_MASK, UNC_IMPL);
        for (int i = 0; i < 12; i++) begin
            ev(22'h1 << UPOS[i], '0, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        rd(OFF_UNC_STATUS, UNC_IMPL);
        wr(OFF_UNC_MASK, 32'h0);
        wr(OFF_UNC_STATUS, 32'hffffffff);
        rd(OFF_UNC_STATUS, 32'h0);
        for (int s = 0; s < 2; s++) begin
            wr(OFF_UNC_SEV, s == 0 ? 32'h0 : 32'hffffffff);
            for (int i = 0; i < 12; i++) begin
                ev(22'h1 << UPOS[i], '0, s[0], !s[0], 1'b0, s == 0 && i == 0);
            end
        end
        rd(OFF_CAP_CTRL, 32'h0);
        wr(OFF_CAP_CTRL, 32'h1f);
        rd(OFF_CAP_CTRL, 32'h0);
        wr(OFF_UNC_STATUS, 32'h0);
        wr(OFF_UNC_STATUS, 32'h10, 4'he);
        rd(OFF_UNC_STATUS, UNC_IMPL);
        wr(OFF_UNC_STATUS, 32'h10, 4'h1);
        rd(OFF_UNC_STATUS, UNC_IMPL & ~32'h10);
        for (int i = 0; i < 6; i++) begin
            ev('0, 14'h1 << CPOS[i], 1'b0, 1'b0, CPOS[i] != 13, 1'b0);
        end
        rd(OFF_COR_STATUS, COR_IMPL);
        wr(OFF_COR_STATUS, 32'h1);
        rd(OFF_COR_STATUS, COR_IMPL & ~32'h1);
        wr(OFF_COR_STATUS, 32'hffffffff);
        rd(OFF_COR_STATUS, 32'h0);
        // link reset: status still records, no messages go out, settings survive
        @(posedge sys_clk);
        hotLinkReset_n <= 1'b0;
        ev(22'h10, 14'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge sys_clk);
        hotLinkReset_n <= 1'b1;
        rd(OFF_COR_STATUS, 32'h1);
        rd(OFF_UNC_SEV, UNC_IMPL);
        rd(OFF_COR_MASK, COR_MASK_RST);
        // two events at once: the pointer must take the lower position
        wr(OFF_UNC_STATUS, 32'h1);
        ev(22'h3000, '0, 1'b1, 1'b0, 1'b0, 1'b1);
        rd(OFF_CAP_CTRL, 32'hc);
        `CHK("fatal count", expFat, fatalCnt)
        `CHK("non-fatal count", expNon, nonFatalCnt)
        `CHK("correctable count", expCor, corCnt)
        test_done;
    end
endmodule
